// ### rtl/clnc_port.sv
// nibble-wide host command port of a character display controller
`timescale 1ns/10ps
// Overview of operation
// - bus cycles are honoured only while chip select is low.
// - a read is a low read strobe, and read data is driven only then.
// - the nibble is captured on the rising edge of the write strobe.
// - register select high writes a character code, low a command.
// - only the top data line is ever driven, the others are inputs.
// - a command read returns busy on the top line, others float.
// - the cursor-direction bit picks decrement (1) or increment (0).
// - the cursor-step bit moves the cursor back (1) or forward (0) now.
// - the cursor-font bit picks blinking block (1) or underline (0).
// - display, cursor and blink commands set their function from bit 0.
// - system reset restores control defaults and keeps both RAMs.
// - the line-select bit picks two lines at 1/16 or one line at 1/8.
module clnc_port (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic register_select_i,
    input wire logic [3:0] nibble_bus_i,
    output logic nibble_bus_top_o,
    output logic nibble_bus_top_oe_o,
    output clnc_pkg::clnc_ctrl_s ctrl_o,
    output logic [clnc_pkg::DDRAM_AW-1:0] cursor_ptr_o,
    output logic cursor_line_o,
    output logic char_we_o,
    output logic [7:0] char_code_o,
    output logic glyph_ram_we_o,
    output logic [clnc_pkg::GRAM_AW-1:0] glyph_ram_addr_o,
    output logic [clnc_pkg::GRAM_DW-1:0] glyph_ram_data_o,
    output logic busy_flag_o
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: two flops before any logic looks at a pin
    logic [7:0] pin_s1_q;
    logic [7:0] pin_s2_q;
    logic wr_n_last_q;
    always_ff @(posedge sys_clk_i) begin
        pin_s1_q <= {cs_n_i, rd_n_i, wr_n_i, register_select_i, nibble_bus_i};
        pin_s2_q <= pin_s1_q;
        wr_n_last_q <= pin_s2_q[5];
    end

    wire logic cs_n_s = pin_s2_q[7];
    wire logic rd_n_s = pin_s2_q[6];
    wire logic wr_n_s = pin_s2_q[5];
    wire logic rsel_s = pin_s2_q[4];
    wire logic [3:0] nib_s = pin_s2_q[3:0];
    // data is still stable at the strobe rise (hold time), so the synced
    // copy taken with the strobe's synced copy is the latched nibble
    wire logic wr_rise = ~wr_n_last_q & wr_n_s & ~cs_n_s;

    ////////////////////////////////////////////////////////////////////////
    // nibble pairing
    clnc_pkg::clnc_nib_e nib_q;
    logic [3:0] hi_q;
    logic rsel_hi_q;
    wire logic byte_done = wr_rise && (nib_q == clnc_pkg::ST_LO);
    wire logic [7:0] byte_w = {hi_q, nib_s};
    wire logic is_char = byte_done & rsel_hi_q;
    wire logic is_cmd = byte_done & ~rsel_hi_q;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            nib_q <= clnc_pkg::ST_HI;
            hi_q <= 4'h0;
            rsel_hi_q <= 1'b0;
        end else if (wr_rise) begin
            unique case (nib_q)
                clnc_pkg::ST_HI: begin
                    hi_q <= nib_s;
                    rsel_hi_q <= rsel_s;
                    nib_q <= clnc_pkg::ST_LO;
                end
                clnc_pkg::ST_LO: begin
                    nib_q <= clnc_pkg::ST_HI;
                end
                default: begin
                    nib_q <= clnc_pkg::ST_HI;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command decode
    function automatic logic op7(input logic [7:0] b, input logic [6:0] c);
        return b[7:1] == c;
    endfunction

    wire logic c_dir = is_cmd & op7(byte_w, clnc_pkg::CMD_DIR);
    wire logic c_step = is_cmd & op7(byte_w, clnc_pkg::CMD_STEP);
    wire logic c_font = is_cmd & op7(byte_w, clnc_pkg::CMD_FONT);
    wire logic c_blink = is_cmd & op7(byte_w, clnc_pkg::CMD_BLINK);
    wire logic c_disp = is_cmd & op7(byte_w, clnc_pkg::CMD_DISP);
    wire logic c_curs = is_cmd & op7(byte_w, clnc_pkg::CMD_CURS);
    wire logic c_line = is_cmd & op7(byte_w, clnc_pkg::CMD_LINE);
    wire logic c_sysrst = is_cmd & (byte_w == clnc_pkg::CMD_SYSRST);
    wire logic c_gaddr = is_cmd & (byte_w[7:4] == clnc_pkg::CMD_GADDR_HI);
    wire logic c_gdata = is_cmd & (byte_w[7:5] == clnc_pkg::CMD_GDATA_HI);
    wire logic c_caddr = is_cmd & (byte_w[7] == clnc_pkg::CMD_CADDR_HI);
    wire logic bit0 = byte_w[0];
    // undefined codes match nothing above and change no state, yet still raise busy
    wire logic any_cmd = is_cmd | is_char;

    ////////////////////////////////////////////////////////////////////////
    // control state
    clnc_pkg::clnc_ctrl_s ctrl_q;
    logic [clnc_pkg::DDRAM_AW-1:0] ptr_q;
    logic line_q;
    logic [clnc_pkg::GRAM_AW-1:0] gaddr_q;
    logic [7:0] busy_cnt_q;
    logic char_we_q;
    logic [7:0] char_q;
    logic gwe_q;
    logic [clnc_pkg::GRAM_DW-1:0] gdata_q;
    logic rd_top_q;
    logic rd_oe_q;

    // char writes move the cursor by the direction that was set
    wire logic step_back = c_step ? bit0 : ctrl_q.dir_dec;
    wire logic do_step = c_step | is_char;
    wire logic [clnc_pkg::DDRAM_AW-1:0] ptr_step = step_back ?
        ptr_q - 6'h01 : ptr_q + 6'h01;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i || c_sysrst) begin
            ctrl_q <= '0;
            ptr_q <= clnc_pkg::PTR_RST;
            line_q <= 1'b0;
            gaddr_q <= '0;
        end else begin
            if (c_dir) ctrl_q.dir_dec <= bit0;
            if (c_font) ctrl_q.font_block <= bit0;
            if (c_blink) ctrl_q.blink_on <= bit0;
            if (c_disp) ctrl_q.display_on <= bit0;
            if (c_curs) ctrl_q.cursor_on <= bit0;
            if (c_line) ctrl_q.two_line <= bit0;
            if (c_caddr) begin
                line_q <= byte_w[clnc_pkg::CADDR_LINE_BIT];
                ptr_q <= byte_w[clnc_pkg::DDRAM_AW-1:0];
            end else if (do_step) begin
                ptr_q <= ptr_step;
            end
            if (c_gaddr) gaddr_q <= byte_w[clnc_pkg::GRAM_AW-1:0];
            else if (gwe_q) gaddr_q <= gaddr_q + 4'h1;
        end
    end

    // write strobes toward the RAMs; ram contents are outside this block
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            char_we_q <= 1'b0;
            char_q <= 8'h00;
            gwe_q <= 1'b0;
            gdata_q <= '0;
        end else begin
            char_we_q <= is_char;
            if (is_char) char_q <= byte_w;
            gwe_q <= c_gdata;
            if (c_gdata) gdata_q <= byte_w[clnc_pkg::GRAM_DW-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // busy: held for the command execution time after every byte
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) busy_cnt_q <= 8'h00;
        else if (any_cmd) busy_cnt_q <= clnc_pkg::EXEC_CYCLES;
        else if (busy_cnt_q != 8'h00) busy_cnt_q <= busy_cnt_q - 8'h01;
    end

    // only the top line turns around; the lower three never drive
    wire logic rd_busy = ~cs_n_s & ~rd_n_s & ~rsel_s;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rd_top_q <= 1'b0;
            rd_oe_q <= 1'b0;
        end else begin
            rd_oe_q <= rd_busy;
            rd_top_q <= (busy_cnt_q != 8'h00);
        end
    end

    assign nibble_bus_top_o = rd_top_q;
    assign nibble_bus_top_oe_o = rd_oe_q;
    assign ctrl_o = ctrl_q;
    assign cursor_ptr_o = ptr_q;
    assign cursor_line_o = line_q;
    assign char_we_o = char_we_q;
    assign char_code_o = char_q;
    assign glyph_ram_we_o = gwe_q;
    assign glyph_ram_addr_o = gaddr_q;
    assign glyph_ram_data_o = gdata_q;
    assign busy_flag_o = rd_top_q;

endmodule // clnc_port

// ### rtl/clnc_pkg.sv
// package: constants, types and command codes of the nibble command port
package clnc_pkg;
    // command byte decode (upper bits select the command)
    localparam logic [6:0] CMD_DIR = 7'h02;
    localparam logic [6:0] CMD_STEP = 7'h03;
    localparam logic [6:0] CMD_FONT = 7'h04;
    localparam logic [6:0] CMD_BLINK = 7'h05;
    localparam logic [6:0] CMD_DISP = 7'h06;
    localparam logic [6:0] CMD_CURS = 7'h07;
    localparam logic [7:0] CMD_SYSRST = 8'h10;
    localparam logic [6:0] CMD_LINE = 7'h09;
    localparam logic [3:0] CMD_GADDR_HI = 4'h2;
    localparam logic [2:0] CMD_GDATA_HI = 3'h2;
    localparam logic [0:0] CMD_CADDR_HI = 1'h1;
    // field positions
    localparam int CADDR_LINE_BIT = 6;
    localparam int DDRAM_AW = 6;
    localparam int GRAM_AW = 4;
    localparam int GRAM_DW = 5;
    // reset values of the control state
    localparam logic [DDRAM_AW-1:0] PTR_RST = 6'h00;
    // execution time: 16 command-clock periods; sys_clk stands in for it
    localparam int EXEC_CLK_PERIODS = 16;
    localparam int SYS_CLK_NS = 10;
    localparam int EXEC_NS = EXEC_CLK_PERIODS * SYS_CLK_NS;
    localparam logic [7:0] EXEC_CYCLES = 8'(EXEC_NS / SYS_CLK_NS);

    typedef struct packed {
        logic display_on;
        logic cursor_on;
        logic blink_on;
        logic font_block;
        logic dir_dec;
        logic two_line;
    } clnc_ctrl_s;

    typedef enum logic [1:0] {
        ST_HI = 2'b00,
        ST_LO = 2'b01
    } clnc_nib_e;
endpackage

// ### testbench/clnc_port_assertions.sv
// checker of the nibble command port
`timescale 1ns/10ps
module clnc_port_assertions (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic register_select_i,
    input wire logic nibble_bus_top_o,
    input wire logic nibble_bus_top_oe_o,
    input wire clnc_pkg::clnc_ctrl_s ctrl_o,
    input wire logic [5:0] cursor_ptr_o,
    input wire logic char_we_o,
    input wire logic glyph_ram_we_o,
    input wire logic busy_flag_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] busy_cnt_q;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !busy_flag_o) busy_cnt_q <= 8'h00;
        else busy_cnt_q <= busy_cnt_q + 8'h01;
    end
    property p_rd_idle; rd_n_i [*5] |-> !nibble_bus_top_oe_o; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("oe without read");
    property p_cs_idle; cs_n_i [*5] |-> !nibble_bus_top_oe_o; endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("oe unselected");
    // every char or glyph-data byte must raise busy right after its ram strobe
    property p_top_busy;
        char_we_o || glyph_ram_we_o |=> busy_flag_o;
    endproperty
    a_top_busy: assert property (p_top_busy) else $error("top not busy");
    property p_rd_oe;
        (!cs_n_i && !rd_n_i && !register_select_i) [*4] |->
            nibble_bus_top_oe_o;
    endproperty
    a_rd_oe: assert property (p_rd_oe) else $error("no oe on read");
    property p_no_we; cs_n_i [*8] |-> !char_we_o && !glyph_ram_we_o; endproperty
    a_no_we: assert property (p_no_we) else $error("write unselected");
    property p_pulse; char_we_o |=> !char_we_o; endproperty
    a_pulse: assert property (p_pulse) else $error("char pulse long");
    property p_cmd; !register_select_i [*8] |-> !char_we_o; endproperty
    a_cmd: assert property (p_cmd) else $error("command as char");
    property p_ctrl; wr_n_i [*8] |-> $stable(ctrl_o); endproperty
    a_ctrl: assert property (p_ctrl) else $error("ctrl moved idle");
    property p_ptr; wr_n_i [*8] |-> $stable(cursor_ptr_o); endproperty
    a_ptr: assert property (p_ptr) else $error("ptr moved idle");
    property p_busy_len; busy_cnt_q <= 8'h10; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy too long");
    c_char: cover property (char_we_o);
    c_glyph: cover property (glyph_ram_we_o);
    c_read: cover property (nibble_bus_top_oe_o && busy_flag_o);
endmodule // clnc_port_assertions
bind clnc_port clnc_port_assertions clnc_port_assertions_i (.*);

// ### testbench/clnc_host.sv
// host processor model driving the nibble bus
`timescale 1ns/10ps
module clnc_host (
    input wire logic clk_i,
    input wire logic top_i,
    output logic cs_n_o = 1'b1,
    output logic rd_n_o = 1'b1,
    output logic wr_n_o = 1'b1,
    output logic rs_o = 1'b0,
    output logic [3:0] nib_o = 4'h0
);
    task automatic put_nib(input logic [3:0] v);
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        nib_o <= v;
        wr_n_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        wr_n_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        cs_n_o <= 1'b1;
        nib_o <= ~v; // released lines never keep the last value
    endtask
    task automatic wr_byte(input logic rs, input logic [7:0] b);
        @(posedge clk_i);
        rs_o <= rs;
        put_nib(b[7:4]);
        put_nib(b[3:0]);
    endtask
    task automatic rd_busy(output logic bf);
        repeat (3) @(posedge clk_i);
        rs_o <= 1'b0;
        cs_n_o <= 1'b0;
        rd_n_o <= 1'b0;
        repeat (5) @(posedge clk_i);
        bf = top_i;
        rd_n_o <= 1'b1;
        cs_n_o <= 1'b1;
    endtask
endmodule // clnc_host

// ### testbench/char_lcd_nibble_command_port_bench.sv
// self-checking bench of the nibble command port
`timescale 1ns/10ps
module char_lcd_nibble_command_port_bench;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cs_n, rd_n, wr_n, rs, top, top_oe, line, cwe, gwe, busy;
    logic [3:0] hn, ga;
    logic [4:0] gd;
    logic [5:0] ptr;
    logic [7:0] code;
    clnc_pkg::clnc_ctrl_s ctrl;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    int pm, dm, fm, bm, im, um, lm, sm, gm;
    logic [7:0] cq[$];
    logic [8:0] gq[$];
    wire [3:0] bus = {top_oe ? top : hn[3], hn[2:0]};
    initial forever #5 sys_clk_i = ~sys_clk_i;
    clnc_host clnc_host_i (.clk_i(sys_clk_i), .top_i(bus[3]), .cs_n_o(cs_n),
        .rd_n_o(rd_n), .wr_n_o(wr_n), .rs_o(rs), .nib_o(hn));
    clnc_port clnc_port_i (.sys_clk_i, .rst_i, .cs_n_i(cs_n), .rd_n_i(rd_n),
        .wr_n_i(wr_n), .register_select_i(rs), .nibble_bus_i(bus),
        .nibble_bus_top_o(top), .nibble_bus_top_oe_o(top_oe), .ctrl_o(ctrl),
        .cursor_ptr_o(ptr), .cursor_line_o(line), .char_we_o(cwe),
        .char_code_o(code), .glyph_ram_we_o(gwe), .glyph_ram_addr_o(ga),
        .glyph_ram_data_o(gd), .busy_flag_o(busy));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cwe === 1'b1) cq.push_back(code);
        if (gwe === 1'b1) gq.push_back({ga, gd});
        if (cyc == 40000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, got);
        total_checks++;
        if (got !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", nm, e, got);
        end
    endtask
    task automatic cmd(input logic r, input logic [7:0] b);
        logic bf;
        clnc_host_i.wr_byte(r, b);
        clnc_host_i.rd_busy(bf);
        chk("busy", 1, bf);
        for (int k = 0; k < 9 && bf !== 1'b0; k++) clnc_host_i.rd_busy(bf);
        chk("idle", 0, bf);
        if (r) pm = im ? pm - 1 : pm + 1;
        else casez (b)
            8'b0000_010?: im = b[0];
            8'b0000_011?: pm = b[0] ? pm - 1 : pm + 1;
            8'b0000_100?: fm = b[0];
            8'b0000_101?: bm = b[0];
            8'b0000_110?: dm = b[0];
            8'b0000_111?: um = b[0];
            8'h10: {pm, lm, sm, gm, dm, um, bm, fm, im} = '0;
            8'b0001_001?: lm = b[0];
            8'b0010_????: gm = b[3:0];
            8'b1???_????: begin
                sm = int'(b[6]);
                pm = int'(b[5:0]);
            end
            default: ;
        endcase
        if (r && cq.size() > 0) chk("code", b, cq.pop_front());
        else if (r) chk("char_we", 1, 0);
        if (!r && b[7:5] == 3'b010) begin
            chk("glyph_we", 1, gq.size());
            if (gq.size() > 0) chk("glyph", {gm[3:0], b[4:0]}, gq.pop_front());
            gm++;
        end
        chk("ctrl", {dm[0], um[0], bm[0], fm[0], im[0], lm[0]}, ctrl);
        chk("ptr", pm[5:0], ptr);
        chk("line", sm[0], line);
    endtask
    initial begin
        logic [7:0] r;
        {pm, lm, sm, gm, dm, um, bm, fm, im} = '0;
        r = 8'($urandom(32'hd57f));
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        for (int i = 4; i < 16; i++) cmd(1'b0, 8'(i));
        cmd(1'b0, 8'h13);
        cmd(1'b0, 8'h12);
        r = 8'($urandom);
        cmd(1'b0, {1'b1, r[6], 2'b01, r[3:0]});
        for (int i = 0; i < 4; i++) begin
            cmd(1'b0, 8'h04 | 8'(i % 2));
            cmd(1'b1, 8'($urandom));
        end
        cmd(1'b0, 8'h2e);
        cmd(1'b0, 8'h40 | 8'($urandom % 32));
        cmd(1'b0, 8'h5f);
        cmd(1'b0, 8'h10);
        cmd(1'b0, 8'h4a);
        cmd(1'b1, 8'h41);
        finish_test();
    end
endmodule // char_lcd_nibble_command_port_bench
